//--- include/sense_monitor_pkg.sv
package sense_monitor_pkg;
	// Functional notes
	// - channel codes 000, 001 and 010 convert the sense amplifier at gain 1x, 4x and 8x.
	// - codes 011 to 110 convert common-mode, output pin, threshold pin and die temperature.
	// - code 111 scans all channels every 2ms using the last selected sense gain.
	// - power-down bit 3 resets to 0; 0 runs normally and 1 shuts the device down.
	// - writing 1 to latch-clear bit 4 releases the output latched in mode 111.
	// - the latch-clear bit clears itself after a 1 is written.
	// - mode 000 is plain op-amp or comparator use with no timing.
	// - mode 111 holds low until the threshold is exceeded for the watchdog delay, then latches high for the retry delay and restarts.
	// - mode 011 regulates for the watchdog delay, then latches high for the retry delay and retries.
	// - an inverting build inverts the output levels of the timed modes.
	// - the delay control register is an 8-bit read and write register.
	// - watchdog select bit 3 gives 1 ms when 0 and 100 us when 1.
	// - retry select bit 2 gives 50ms when 0 and 10ms when 1.
	// - reset forces every register to its default until released.
	// - the mode and channel register resets to zero, mode in bits 7:5, channel in bits 2:0.

	// register addresses and reset values
	localparam logic [7:0] MODE_CHANNEL_ADDR  = 8'h0a;
	localparam logic [7:0] FAULT_DELAY_ADDR   = 8'h0b;
	localparam logic [7:0] MODE_CHANNEL_RESET = 8'h00;
	localparam logic [7:0] FAULT_DELAY_RESET  = 8'h00;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;

	// field positions
	localparam int CHANNEL_LSB      = 0;
	localparam int POWER_DOWN_BIT   = 3;
	localparam int LATCH_CLEAR_BIT  = 4;
	localparam int MODE_LSB         = 5;
	localparam int WATCHDOG_SEL_BIT = 3;
	localparam int RETRY_SEL_BIT    = 2;

	// output mode codes
	localparam logic [2:0] MODE_PLAIN       = 3'h0;
	localparam logic [2:0] MODE_OPAMP_RETRY = 3'h3;
	localparam logic [2:0] MODE_COMP_RETRY  = 3'h7;

	// channel select codes
	localparam logic [2:0] CHAN_SENSE_X1  = 3'h0;
	localparam logic [2:0] CHAN_SENSE_X4  = 3'h1;
	localparam logic [2:0] CHAN_SENSE_X8  = 3'h2;
	localparam logic [2:0] CHAN_COMMON    = 3'h3;
	localparam logic [2:0] CHAN_OUT_PIN   = 3'h4;
	localparam logic [2:0] CHAN_THRESHOLD = 3'h5;
	localparam logic [2:0] CHAN_TEMP      = 3'h6;
	localparam logic [2:0] CHAN_SCAN      = 3'h7;

	// converter source and gain codes driven to the converter
	typedef enum logic [2:0] {
		SRC_SENSE,
		SRC_COMMON,
		SRC_OUT_PIN,
		SRC_THRESHOLD,
		SRC_TEMP
	} adc_src_e;
	localparam logic [1:0] GAIN_X1 = 2'h0;
	localparam logic [1:0] GAIN_X4 = 2'h1;
	localparam logic [1:0] GAIN_X8 = 2'h2;
	localparam logic [2:0] SCAN_LAST = 3'h4;

	// timing, times in ns, counts rounded up to whole cycles
	localparam int CLK_PERIOD_NS     = 20;
	localparam int WATCHDOG_LONG_NS  = 1_000_000;
	localparam int WATCHDOG_SHORT_NS = 100_000;
	localparam int RETRY_LONG_NS     = 50_000_000;
	localparam int RETRY_SHORT_NS    = 10_000_000;
	localparam int SCAN_PERIOD_NS    = 2_000_000;
	localparam int WATCHDOG_LONG_CYC  = (WATCHDOG_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WATCHDOG_SHORT_CYC = (WATCHDOG_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_LONG_CYC     = (RETRY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_SHORT_CYC    = (RETRY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCAN_PERIOD_CYC    = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COUNT_W = 22;
endpackage : sense_monitor_pkg

//--- include/reg_xfer_if.sv
`timescale 1ns/1ps
// register request crossing from the link domain to the core domain
interface reg_xfer_if;
	logic       req_toggle;
	logic       is_write;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack_toggle;
	logic [7:0] rdata;

	modport link (output req_toggle, output is_write, output addr, output wdata,
		input ack_toggle, input rdata);
	modport core (input req_toggle, input is_write, input addr, input wdata,
		output ack_toggle, output rdata);
endinterface : reg_xfer_if

//--- hw/link_xfer.sv
`timescale 1ns/1ps
// link-side half of the register crossing: holds the request, waits for the ack
module link_xfer
(
	// link clock and reset
	input  wire logic       link_clk_in,
	input  wire logic       rst_n_in,
	// link register port
	input  wire logic       link_req_in,
	input  wire logic       link_write_in,
	input  wire logic [7:0] link_addr_in,
	input  wire logic [7:0] link_wdata_in,
	output logic            link_busy_out,
	output logic            link_done_out,
	output logic [7:0]      link_rdata_out,
	// crossing toward the core
	reg_xfer_if.link        xfer
);
	logic       req_toggle;
	logic       is_write;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack_meta;
	logic       ack_sync;
	logic       ack_seen;
	wire        ack_event = ack_sync ^ ack_seen;
	// a request still held in its done cycle is the one just answered, never a new one
	wire        take_req  = link_req_in && !link_busy_out && !link_done_out;

	assign xfer.req_toggle = req_toggle;
	assign xfer.is_write   = is_write;
	assign xfer.addr       = addr;
	assign xfer.wdata      = wdata;

	// request hold; address and data stay still until the ack returns
	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			req_toggle <= 1'b0;
			is_write   <= 1'b0;
			addr       <= 8'h00;
			wdata      <= 8'h00;
		end
		else if (take_req)
		begin
			req_toggle <= ~req_toggle;
			is_write   <= link_write_in;
			addr       <= link_addr_in;
			wdata      <= link_wdata_in;
		end
	end

	// ack synchroniser; only the second stage is looked at
	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
			ack_seen <= 1'b0;
		end
		else
		begin
			ack_meta <= xfer.ack_toggle;
			ack_sync <= ack_meta;
			ack_seen <= ack_sync;
		end
	end

	// busy, done pulse and read data capture
	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			link_busy_out  <= 1'b0;
			link_done_out  <= 1'b0;
			link_rdata_out <= 8'h00;
		end
		else
		begin
			link_done_out <= ack_event;
			if (take_req)
				link_busy_out <= 1'b1;
			else if (ack_event)
				link_busy_out <= 1'b0;
			if (ack_event)
				link_rdata_out <= xfer.rdata; // stable since the ack toggled
		end
	end
endmodule : link_xfer

//--- hw/sense_monitor_control_regs.sv
`timescale 1ns/1ps
// control registers, converter steering and timed fault output of the monitor
module sense_monitor_control_regs
	import sense_monitor_pkg::*;
#(
	parameter bit INVERTING           = 1'b0,
	parameter int WATCHDOG_LONG_CYCLES  = sense_monitor_pkg::WATCHDOG_LONG_CYC,
	parameter int WATCHDOG_SHORT_CYCLES = sense_monitor_pkg::WATCHDOG_SHORT_CYC,
	parameter int RETRY_LONG_CYCLES     = sense_monitor_pkg::RETRY_LONG_CYC,
	parameter int RETRY_SHORT_CYCLES    = sense_monitor_pkg::RETRY_SHORT_CYC,
	parameter int SCAN_PERIOD_CYCLES    = sense_monitor_pkg::SCAN_PERIOD_CYC
)
(
	// core clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	// link register port
	input  wire logic       link_clk_in,
	input  wire logic       link_req_in,
	input  wire logic       link_write_in,
	input  wire logic [7:0] link_addr_in,
	input  wire logic [7:0] link_wdata_in,
	output logic            link_busy_out,
	output logic            link_done_out,
	output logic [7:0]      link_rdata_out,
	// converter steering
	input  wire logic       adc_done_in,
	output sense_monitor_pkg::adc_src_e adc_src_out,
	output logic [1:0]      adc_gain_out,
	output logic            adc_start_out,
	output logic            power_down_out,
	// fault output
	input  wire logic       sense_above_in,
	output logic            fault_level_out,
	output logic            regulate_out,
	output logic            latched_out
);
	import sense_monitor_pkg::*;

	// count parameters must fit the interval counter
	localparam longint COUNT_MAX = (64'd1 << COUNT_W) - 64'd1;
	generate
		if (WATCHDOG_LONG_CYCLES < 1 || WATCHDOG_SHORT_CYCLES < 1 ||
			RETRY_LONG_CYCLES < 1 || RETRY_SHORT_CYCLES < 1 || SCAN_PERIOD_CYCLES < 1 ||
			longint'(RETRY_LONG_CYCLES) > COUNT_MAX || longint'(SCAN_PERIOD_CYCLES) > COUNT_MAX ||
			longint'(WATCHDOG_LONG_CYCLES) > COUNT_MAX ||
			longint'(WATCHDOG_SHORT_CYCLES) > COUNT_MAX ||
			longint'(RETRY_SHORT_CYCLES) > COUNT_MAX)
		begin : bad_counts
			$error("interval counts must lie between 1 and the counter range");
		end
	endgenerate

	localparam logic [COUNT_W-1:0] WD_LONG  = COUNT_W'(WATCHDOG_LONG_CYCLES);
	localparam logic [COUNT_W-1:0] WD_SHORT = COUNT_W'(WATCHDOG_SHORT_CYCLES);
	localparam logic [COUNT_W-1:0] RT_LONG  = COUNT_W'(RETRY_LONG_CYCLES);
	localparam logic [COUNT_W-1:0] RT_SHORT = COUNT_W'(RETRY_SHORT_CYCLES);
	localparam logic [COUNT_W-1:0] SCAN_LEN = COUNT_W'(SCAN_PERIOD_CYCLES);
	localparam logic [COUNT_W-1:0] ONE      = COUNT_W'(1);

	typedef enum logic [1:0] {
		FLT_IDLE,
		FLT_WATCH,
		FLT_LATCHED
	} fault_state_e;

	// picks the long or the short interval from a select bit
	function automatic logic [COUNT_W-1:0] pick_len(input logic sel,
		input logic [COUNT_W-1:0] when_0, input logic [COUNT_W-1:0] when_1);
		pick_len = sel ? when_1 : when_0;
	endfunction : pick_len

	// maps a single-channel select code to converter source
	function automatic adc_src_e src_of_code(input logic [2:0] code);
		unique case (code)
			CHAN_COMMON:    src_of_code = SRC_COMMON;
			CHAN_OUT_PIN:   src_of_code = SRC_OUT_PIN;
			CHAN_THRESHOLD: src_of_code = SRC_THRESHOLD;
			CHAN_TEMP:      src_of_code = SRC_TEMP;
			default:        src_of_code = SRC_SENSE;
		endcase
	endfunction : src_of_code

	reg_xfer_if xfer ();

	// link-domain half of the crossing
	link_xfer u_link_xfer
	(
		.link_clk_in    (link_clk_in),
		.rst_n_in       (rst_n_in),
		.link_req_in    (link_req_in),
		.link_write_in  (link_write_in),
		.link_addr_in   (link_addr_in),
		.link_wdata_in  (link_wdata_in),
		.link_busy_out  (link_busy_out),
		.link_done_out  (link_done_out),
		.link_rdata_out (link_rdata_out),
		.xfer           (xfer.link)
	);

	// registers and core state
	logic [7:0]         mode_channel_control;
	logic [7:0]         fault_delay_control;
	logic               latch_clear;
	logic [1:0]         last_gain;
	logic               req_meta;
	logic               req_sync;
	logic               req_seen;
	logic               ack_toggle;
	logic [7:0]         rdata_hold;
	logic               above_meta;
	logic               above_sync;
	fault_state_e       state;
	fault_state_e       next_state;
	logic [COUNT_W-1:0] interval_cnt;
	logic [COUNT_W-1:0] next_interval_cnt;
	logic [COUNT_W-1:0] scan_cnt;
	logic               scan_busy;
	logic [2:0]         scan_idx;

	assign xfer.ack_toggle = ack_toggle;
	assign xfer.rdata      = rdata_hold;

	// register decode
	wire        req_event   = req_sync ^ req_seen;
	wire        hit_mode    = xfer.addr == MODE_CHANNEL_ADDR;
	wire        hit_delay   = xfer.addr == FAULT_DELAY_ADDR;
	wire        wr_mode     = req_event && xfer.is_write && hit_mode;
	wire        wr_delay    = req_event && xfer.is_write && hit_delay;
	wire [7:0]  read_word   = hit_mode  ? mode_channel_control :
		hit_delay ? fault_delay_control : UNMAPPED_READ;
	wire [2:0]  chan_code   = mode_channel_control[CHANNEL_LSB +: 3];
	wire [2:0]  out_mode    = mode_channel_control[MODE_LSB +: 3];
	wire        power_down  = mode_channel_control[POWER_DOWN_BIT];
	wire [2:0]  wr_chan     = xfer.wdata[CHANNEL_LSB +: 3];
	wire        mode_comp   = out_mode == MODE_COMP_RETRY;
	wire        mode_opamp  = out_mode == MODE_OPAMP_RETRY;
	wire        timed_mode  = mode_comp || mode_opamp;
	wire        scan_mode   = chan_code == CHAN_SCAN && !power_down;
	wire        scan_tick   = scan_mode && scan_cnt == ONE;
	wire        scan_step   = scan_mode && scan_busy && adc_done_in && scan_idx != SCAN_LAST;
	// source of the start being launched, so a start never carries the previous channel
	wire [2:0]  scan_src    = scan_tick ? 3'h0 : scan_step ? scan_idx + 3'h1 : scan_idx;
	wire [COUNT_W-1:0] watch_len =
		pick_len(fault_delay_control[WATCHDOG_SEL_BIT], WD_LONG, WD_SHORT);
	wire [COUNT_W-1:0] retry_len =
		pick_len(fault_delay_control[RETRY_SEL_BIT], RT_LONG, RT_SHORT);

	// request synchroniser; only the second stage is looked at
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_seen <= 1'b0;
		end
		else
		begin
			req_meta <= xfer.req_toggle;
			req_sync <= req_meta;
			req_seen <= req_sync;
		end
	end

	// register writes; the latch-clear bit never stores, it only pulses
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mode_channel_control <= MODE_CHANNEL_RESET;
			fault_delay_control  <= FAULT_DELAY_RESET;
			latch_clear          <= 1'b0;
		end
		else
		begin
			latch_clear <= wr_mode && xfer.wdata[LATCH_CLEAR_BIT];
			if (wr_mode)
			begin
				mode_channel_control <= xfer.wdata;
				mode_channel_control[LATCH_CLEAR_BIT] <= 1'b0;
			end
			if (wr_delay)
				fault_delay_control <= xfer.wdata;
		end
	end

	// read answer; data is held on the same edge the ack toggles, so the link samples it settled
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ack_toggle <= 1'b0;
			rdata_hold <= 8'h00;
		end
		else if (req_event)
		begin
			ack_toggle <= ~ack_toggle;
			rdata_hold <= read_word;
		end
	end

	// last sense gain, kept for the scan
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			last_gain <= GAIN_X1;
		else if (wr_mode && wr_chan <= CHAN_SENSE_X8)
			last_gain <= wr_chan[1:0];
	end

	// scan period counter and channel walk, advanced by converter completion
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scan_cnt  <= SCAN_LEN;
			scan_busy <= 1'b0;
			scan_idx  <= 3'h0;
		end
		else if (!scan_mode)
		begin
			scan_cnt  <= SCAN_LEN;
			scan_busy <= 1'b0;
			scan_idx  <= 3'h0;
		end
		else
		begin
			scan_cnt <= scan_tick ? SCAN_LEN : scan_cnt - ONE;
			if (scan_tick)
			begin
				scan_busy <= 1'b1;
				scan_idx  <= 3'h0;
			end
			else if (scan_step)
				scan_idx <= scan_idx + 3'h1;
			else if (scan_busy && adc_done_in)
				scan_busy <= 1'b0; // last channel done, index stays in range
		end
	end

	// converter steering outputs
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			adc_src_out    <= SRC_SENSE;
			adc_gain_out   <= GAIN_X1;
			adc_start_out  <= 1'b0;
			power_down_out <= 1'b0;
		end
		else
		begin
			power_down_out <= power_down;
			adc_start_out  <= scan_tick || scan_step;
			if (scan_mode)
			begin
				adc_src_out  <= adc_src_e'(scan_src);
				adc_gain_out <= last_gain;
			end
			else
			begin
				adc_src_out  <= src_of_code(chan_code);
				adc_gain_out <= chan_code <= CHAN_SENSE_X8 ? chan_code[1:0] : last_gain;
			end
		end
	end

	// comparator level comes from the analog side, so it is synchronised first
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			above_meta <= 1'b0;
			above_sync <= 1'b0;
		end
		else
		begin
			above_meta <= sense_above_in;
			above_sync <= above_meta;
		end
	end

	// fault timing; interval length is loaded at the start and then left alone
	always_comb
	begin
		next_state        = state;
		next_interval_cnt = interval_cnt;
		unique case (state)
			FLT_IDLE:
				if (timed_mode && !power_down && above_sync)
				begin
					next_state        = FLT_WATCH;
					next_interval_cnt = watch_len;
				end
			FLT_WATCH:
				if (!timed_mode || power_down || !above_sync)
					next_state = FLT_IDLE;
				else if (interval_cnt == ONE)
				begin
					next_state        = FLT_LATCHED;
					next_interval_cnt = retry_len;
				end
				else
					next_interval_cnt = interval_cnt - ONE;
			FLT_LATCHED:
				if (!timed_mode || power_down)
					next_state = FLT_IDLE;
				else if (latch_clear && mode_comp)
					next_state = FLT_IDLE;
				else if (interval_cnt == ONE)
					next_state = FLT_IDLE;
				else
					next_interval_cnt = interval_cnt - ONE;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state        <= FLT_IDLE;
			interval_cnt <= ONE;
		end
		else
		begin
			state        <= next_state;
			interval_cnt <= next_interval_cnt;
		end
	end

	// output level: plain mode follows the comparator, timed modes follow the latch
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			fault_level_out <= INVERTING;
			regulate_out    <= 1'b0;
			latched_out     <= 1'b0;
		end
		else
		begin
			latched_out  <= state == FLT_LATCHED;
			regulate_out <= !power_down && (out_mode == MODE_PLAIN ||
				(mode_opamp && state != FLT_LATCHED));
			if (power_down)
				fault_level_out <= INVERTING;
			else if (timed_mode)
				fault_level_out <= (state == FLT_LATCHED) ^ INVERTING;
			else
				fault_level_out <= above_sync;
		end
	end
endmodule : sense_monitor_control_regs

//--- bench/sense_monitor_asserts.sv
`timescale 1ns/1ps
// port-level checks of the fault timer, converter start and link handshake
module sense_monitor_asserts
	import sense_monitor_pkg::*;
#(
	parameter bit INVERTING             = 1'b0,
	parameter int WATCHDOG_SHORT_CYCLES = 8,
	parameter int RETRY_LONG_CYCLES     = 40
)
(
	// clocks and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	// watched ports
	input wire logic link_busy_out,
	input wire logic link_done_out,
	input wire logic adc_start_out,
	input wire logic power_down_out,
	input wire logic sense_above_in,
	input wire logic fault_level_out,
	input wire logic regulate_out,
	input wire logic latched_out
);
	int latch_cycles;

	// length of the current latched spell; a counter avoids a huge repetition
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			latch_cycles <= 0;
		else
			latch_cycles <= latched_out ? latch_cycles + 1 : 0;
	end

	// a taken request must be answered within a bounded number of link cycles
	sequence s_taken;
		$rose(link_busy_out);
	endsequence
	sequence s_answered;
		##[1:16] link_done_out;
	endsequence

	xfer_done_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
		s_taken |-> s_answered) else $error("request not answered");
	done_pulse_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
		link_done_out |=> !link_done_out) else $error("done longer than one cycle");
	pd_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		power_down_out [*3] |-> !latched_out && fault_level_out == INVERTING)
		else $error("output active in power down");
	latch_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		latched_out && $past(latched_out) |-> fault_level_out == !INVERTING)
		else $error("latched level wrong");
	watch_first_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$rose(latched_out) |-> $past(sense_above_in, WATCHDOG_SHORT_CYCLES))
		else $error("latched without watchdog spell");
	retry_bound_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		latch_cycles <= RETRY_LONG_CYCLES + 1) else $error("latch held past retry delay");
	latch_regulate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		latched_out && $past(latched_out) |-> !regulate_out)
		else $error("regulating while latched");
	start_pulse_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		adc_start_out |-> !power_down_out ##1 !adc_start_out) else $error("bad start pulse");
endmodule : sense_monitor_asserts

bind sense_monitor_control_regs sense_monitor_asserts #(.INVERTING(INVERTING),
	.WATCHDOG_SHORT_CYCLES(WATCHDOG_SHORT_CYCLES), .RETRY_LONG_CYCLES(RETRY_LONG_CYCLES))
	sense_monitor_asserts_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.link_clk_in(link_clk_in), .link_busy_out(link_busy_out), .link_done_out(link_done_out),
	.adc_start_out(adc_start_out), .power_down_out(power_down_out),
	.sense_above_in(sense_above_in), .fault_level_out(fault_level_out),
	.regulate_out(regulate_out), .latched_out(latched_out));

//--- bench/link_master_model.sv
`timescale 1ns/1ps
// link master: runs the link clock only while a frame is open
module link_master_model
(
	// link side
	output logic            link_clk_out,
	output logic            req_out,
	output logic            write_out,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out,
	input  wire logic       done_in,
	input  wire logic [7:0] rdata_in
);
	bit run = 1'b0;

	// lines idle at time zero; clock held low between frames, phase free of the core
	initial
	begin
		req_out = 1'b0;
		write_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
		link_clk_out = 1'b0;
		#7;
		forever #80 link_clk_out = run & ~link_clk_out;
	end

	task spin(input int n);
		run = 1'b1;
		repeat (n) @(posedge link_clk_out);
		run = 1'b0;
	endtask : spin

	// one byte transfer; request held until done is seen or 40 link cycles pass, then released
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		run = 1'b1;
		q = 8'hxx;
		@(posedge link_clk_out);
		req_out <= 1'b1;
		write_out <= w;
		addr_out <= a;
		wdata_out <= (a == 8'h0b) ? (d & 8'h0c) : d;
		for (int n = 0; n < 40; n++)
		begin
			@(posedge link_clk_out);
			if (done_in === 1'b1)
				break;
		end
		if (done_in === 1'b1)
			q = rdata_in;
		req_out <= 1'b0;
		addr_out <= ~addr_out;
		wdata_out <= ~wdata_out;
		repeat (2) @(posedge link_clk_out);
		run = 1'b0;
	endtask : xfer
endmodule : link_master_model

//--- bench/test_sense_monitor_control_regs.sv
`timescale 1ns/1ps
// self-checking bench with converter and comparator stand-ins
module test_sense_monitor_control_regs;
	import sense_monitor_pkg::*;
	localparam int WL = 20;
	localparam int WS = 8;
	localparam int RL = 400;
	localparam int SCAN = 64;
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       link_clk;
	logic       link_req;
	logic       link_write;
	logic [7:0] link_addr;
	logic [7:0] link_wdata;
	logic       link_done;
	logic [7:0] link_rdata;
	logic       adc_done = 1'b0;
	logic       adc_pre = 1'b0;
	adc_src_e   adc_src;
	logic [1:0] adc_gain;
	logic       adc_start;
	logic       power_down;
	logic       sense_above = 1'b0;
	logic       fault_level;
	logic       regulate;
	logic       latched;
	logic [4:0] starts[$];
	logic [7:0] q;
	logic [7:0] d;
	logic [1:0] g;
	logic [2:0] modes [2] = '{MODE_COMP_RETRY, MODE_OPAMP_RETRY};
	int         err_total = 0;
	int         checks_done = 0;
	int         lat_run = 0;
	int         n;

	always #10 core_clk = ~core_clk;

	sense_monitor_control_regs #(.WATCHDOG_LONG_CYCLES(WL), .WATCHDOG_SHORT_CYCLES(WS),
		.RETRY_LONG_CYCLES(RL), .RETRY_SHORT_CYCLES(160), .SCAN_PERIOD_CYCLES(SCAN))
	sense_monitor_control_regs_inst (.core_clk_in(core_clk), .rst_n_in(rst_n),
		.link_clk_in(link_clk), .link_req_in(link_req), .link_write_in(link_write),
		.link_addr_in(link_addr), .link_wdata_in(link_wdata), .link_busy_out(),
		.link_done_out(link_done), .link_rdata_out(link_rdata), .adc_done_in(adc_done),
		.adc_src_out(adc_src), .adc_gain_out(adc_gain), .adc_start_out(adc_start),
		.power_down_out(power_down), .sense_above_in(sense_above),
		.fault_level_out(fault_level), .regulate_out(regulate), .latched_out(latched));

	link_master_model link_master_model_inst (.link_clk_out(link_clk), .req_out(link_req),
		.write_out(link_write), .addr_out(link_addr), .wdata_out(link_wdata),
		.done_in(link_done), .rdata_in(link_rdata));

	// converter answers each start two cycles on; latched spells are measured here
	always @(posedge core_clk)
	begin
		adc_pre <= adc_start;
		adc_done <= adc_pre;
		lat_run <= (latched === 1'b1) ? lat_run + 1 : 0;
		if (adc_start === 1'b1)
			starts.push_back({adc_src, adc_gain});
	end

	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task chk_in(input string what, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi)
		begin
			err_total++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_in

	task xf(input logic w, input logic [7:0] a, input logic [7:0] v);
		link_master_model_inst.xfer(w, a, v, q);
	endtask : xf

	task wait_lat(input logic v);
		n = 0;
		while (latched !== v && n < 1000)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask : wait_lat

	task test_done;
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// watchdog well beyond the expected run length
	initial
	begin
		#1_000_000;
		err_total++;
		test_done();
	end

	initial
	begin
		void'($urandom(32'hd30fb225));
		// one link edge clears the link half; release follows that link edge, after the fourth core edge
		fork
			link_master_model_inst.spin(1);
			repeat (3) @(posedge core_clk);
		join
		rst_n <= 1'b1;
		link_master_model_inst.spin(2);
		xf(1'b0, MODE_CHANNEL_ADDR, 8'h00);
		chk("mode reset", 8'h00, q);
		xf(1'b0, FAULT_DELAY_ADDR, 8'h00);
		chk("delay reset", 8'h00, q);
		xf(1'b0, 8'h05, 8'h00);
		chk("unmapped", UNMAPPED_READ, q);
		d = 8'($urandom()) & 8'h0c;
		xf(1'b1, FAULT_DELAY_ADDR, d);
		xf(1'b0, FAULT_DELAY_ADDR, 8'h00);
		chk("delay readback", d, q);
		// fixed channels steer source and gain
		for (int c = 0; c < 7; c++)
		begin
			xf(1'b1, MODE_CHANNEL_ADDR, 8'(c));
			repeat (4) @(posedge core_clk);
			chk("src", (c < 3) ? 8'h00 : 8'(c - 2), {5'h00, adc_src});
			if (c < 3)
				chk("gain", 8'(c), {6'h00, adc_gain});
		end
		// scan keeps the last sense gain
		g = 2'($urandom_range(2));
		xf(1'b1, MODE_CHANNEL_ADDR, {6'h00, g});
		starts.delete();
		xf(1'b1, MODE_CHANNEL_ADDR, {5'h00, CHAN_SCAN});
		repeat (SCAN + 40) @(posedge core_clk);
		chk_in("scan starts", 5, 99, starts.size());
		for (int k = 0; k < 5 && k < starts.size(); k++)
			chk("scan entry", {3'h0, 3'(k), g}, {3'h0, starts[k]});
		// power down halts the scan
		xf(1'b1, MODE_CHANNEL_ADDR, 8'h0f);
		starts.delete();
		repeat (SCAN * 2) @(posedge core_clk);
		chk("power down", 8'h01, {6'h00, regulate, power_down});
		chk("starts in down", 8'h00, 8'(starts.size()));
		xf(1'b1, MODE_CHANNEL_ADDR, 8'h00);
		@(posedge core_clk);
		sense_above <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk("plain high", 8'h05, {5'h00, regulate, latched, fault_level});
		sense_above <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk("plain low", 8'h04, {5'h00, regulate, latched, fault_level});
		// timed modes: watchdog, retry, delay change mid-interval, latch clear
		for (int i = 0; i < 2; i++)
		begin
			xf(1'b1, FAULT_DELAY_ADDR, 8'h00);
			xf(1'b1, MODE_CHANNEL_ADDR, {modes[i], 5'h00});
			@(posedge core_clk);
			sense_above <= 1'b1;
			wait_lat(1'b1);
			chk_in("watch long", WL, WL + 6, n);
			xf(1'b1, FAULT_DELAY_ADDR, 8'h0c);
			wait_lat(1'b0);
			chk_in("retry long", RL - 1, RL + 1, lat_run);
			wait_lat(1'b1);
			chk_in("watch short", WS, WS + 6, n);
			@(posedge core_clk);
			sense_above <= 1'b0;
			xf(1'b1, MODE_CHANNEL_ADDR, {modes[i], 5'h10});
			chk("latch clear", {7'h00, modes[i] != MODE_COMP_RETRY}, {7'h00, latched});
			xf(1'b0, MODE_CHANNEL_ADDR, 8'h00);
			chk("clear bit", {modes[i], 5'h00}, q);
			wait_lat(1'b0);
		end
		test_done();
	end
endmodule : test_sense_monitor_control_regs
